// ### include/pin_cfg_pkg.sv
// constants, register map and carrier types for the pin configuration block
// assumes a 250 MHz system clock and an Avalon-MM register port
package pin_cfg_pkg;

  localparam int PIN_COUNT = 10;
  localparam int AVS_ADDR_W = 10;
  localparam int AVS_DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SERIAL_PORT6_OPTIONS = 8'h31;
  localparam logic [7:0] IDX_SLOW_CLOCK_OUTPUT_CTRL = 8'h3c;
  // pin order: 0x32,0x33,0x34,0x35,0x36,0x37,0x39,0x3a,0x3b,0x3d
  localparam logic [PIN_COUNT-1:0][7:0] PIN_CFG_IDX = {
    8'h3d, 8'h3b, 8'h3a, 8'h39, 8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32};

  localparam int PIN_SMI_OR_KBC_BIT = 0;
  localparam int PIN_FRONT_PANEL_RESET = 1;
  localparam int PIN_RING_IND4 = 2;
  localparam int PIN_MOUSE_DATA = 3;
  localparam int PIN_MOUSE_CLOCK = 4;
  localparam int PIN_TERM_READY4 = 5;
  localparam int PIN_KBD_RESET = 6;
  localparam int PIN_ADDR_GATE = 7;
  localparam int PIN_DENSITY0 = 8;
  localparam int PIN_WAKE_EVENT = 9;

  localparam logic [PIN_COUNT-1:0][7:0] PIN_CFG_RESET = {
    8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h84, 8'h84, 8'h01, 8'h05, 8'h01};
  localparam logic [PIN_COUNT-1:0][7:0] PIN_CFG_WMASK = {
    8'h87, 8'h87, 8'h87, 8'h87, 8'h03, 8'h87, 8'h87, 8'h03, 8'h87, 8'h8f};
  localparam logic [PIN_COUNT-1:0][7:0] PIN_CFG_FIXED1 = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};

  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_ALT_BIT = 2;
  localparam int CFG_ALT2_LSB = 2;
  localparam int CFG_OTYPE_BIT = 7;
  localparam logic [7:0] CFG_ALT_MASK = 8'h04;
  localparam logic [1:0] ALT2_SMI = 2'h1;
  localparam logic [1:0] ALT2_KBC = 2'h2;
  localparam int SERIAL_PORTS_FOR_P4 = 4;
  localparam int SERIAL_PORTS_FOR_P6 = 6;

  localparam int SP6_OUT_SEL_BIT = 0;
  localparam int SP6_IN_LSB = 1;
  localparam int SP6_DIR_EN_BIT = 3;
  localparam int SP6_DIR_SIG_BIT = 4;
  localparam int SP6_DIR_POL_BIT = 5;
  localparam logic [7:0] SP6_RESET = 8'h04;
  localparam logic [7:0] SP6_WMASK = 8'h3f;
  localparam logic [1:0] SP6_IN_DCD = 2'h3;
  localparam logic [1:0] SP6_IN_RI = 2'h2;
  localparam logic [1:0] SP6_IN_CTS = 2'h1;
  localparam logic [1:0] SP6_IN_DSR = 2'h0;

  localparam int CLKO_EN_BIT = 0;
  localparam int CLKO_FREQ_LSB = 1;
  localparam logic [7:0] CLKO_RESET = 8'h00;
  localparam logic [7:0] CLKO_WMASK = 8'h0f;
  localparam logic [2:0] CLKO_FREQ_RSVD = 3'h7;
  localparam logic [5:0] CLKO_MASK_FULL = 6'h3f;

  // timing: ticks at twice the fastest output rate
  localparam int CLK_SYS_HZ = 250_000_000;
  localparam int CLKO_TOP_HZ = 16;
  localparam int CLKO_TICK_HZ = 2 * CLKO_TOP_HZ;
  localparam int TICK_CYCLES = CLK_SYS_HZ / CLKO_TICK_HZ;

  typedef struct packed {
    logic read;
    logic write;
    logic [AVS_ADDR_W-1:0] address;
    logic [AVS_DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [AVS_DATA_W-1:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

  typedef struct packed {
    logic request_to_send_p6;
    logic terminal_ready_p6;
    logic tx_active;
  } sp6_modem_out_t;

  typedef struct packed {
    logic carrier_detect_p6;
    logic ring_indicator_p6;
    logic clear_to_send_p6;
    logic set_ready_p6;
  } sp6_modem_in_t;

endpackage

// ### core/slow_clock_gen.sv
// programmable low-frequency clock output, 0.25 Hz to 16 Hz
// assumes enable and frequency code come from registers in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module slow_clock_gen #(
  parameter int TICK_CYCLES = pin_cfg_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,         // system clock
  input wire logic rst,             // asynchronous reset, active high
  input wire logic enable,          // clock output enable
  input wire logic [2:0] freq_sel,  // frequency code
  output var logic clk_out          // divided clock, low when off
);

  typedef struct packed {
    logic [31:0] div_cnt;
    logic [5:0] step_cnt;
    logic clk_out;
  } clk_state_t;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  clk_state_t st_q;
  clk_state_t st_d;
  logic [5:0] half_mask;

  always_comb begin
    st_d = st_q;
    // half period in ticks is 64 >> code
    half_mask = pin_cfg_pkg::CLKO_MASK_FULL >> freq_sel;
    if (!enable || freq_sel == pin_cfg_pkg::CLKO_FREQ_RSVD) begin
      st_d = '0;
    end else if (st_q.div_cnt == TICK_LAST) begin
      st_d.div_cnt = '0;
      st_d.step_cnt = st_q.step_cnt + 6'h01;
      if ((st_q.step_cnt & half_mask) == half_mask) begin
        st_d.clk_out = ~st_q.clk_out;
      end
    end else begin
      st_d.div_cnt = st_q.div_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign clk_out = st_q.clk_out;

endmodule
`default_nettype wire

// ### core/pin_config_and_clock_out.sv
// per-pin configuration, alternate function routing, serial port 6 options
// and the slow clock output control, behind an Avalon-MM slave
// assumes pin inputs and alternate function signals are synchronous to clk_sys
//
// Operation
// - config bit 0: one makes the pin an input, zero an output
// - config bit 1: one inverts the pin value, zero passes it
// - config bit 7: one gives open-drain, zero push-pull
// - pins at 0x34 and 0x37: bit 7 read-only, always one
// - pin 0x32 bits 3:2: 10 keyboard port bit, 01 irq, 00 gpio
// - pin 0x33 resets to 0x05; bit 2 selects front panel reset input
// - pins 0x35/0x36 reset 0x84; bit 2 selects mouse data/clock
// - 0x34 bit 2 routes ring indicator of port four, four-port variants
// - 0x39 bit 2 routes keyboard system reset output
// - 0x3a bit 2 routes address line 20 gate output
// - 0x3b bit 2 routes drive density select zero
// - clock control resets to zero; bit 0 enables the clock output
// - clock bits 3:1 pick 0.25 to 16 Hz; code 111 reserved
// - 0x3d bit 2 selects wake output, active low when not inverted
// - port 6 options bit 0: one request-to-send, zero terminal-ready out
// - port 6 options bits 2:1 choose which modem input the pin feeds
// - port 6 options bit 3 enables automatic transmit direction control
// - port 6 options bit 4: direction on request-to-send or terminal-ready
// - port 6 options bit 5 zero: direction line low while transmitting
// - most pin registers reset to 0x01: plain non-inverted input
`timescale 1ns/1ps
`default_nettype none
module pin_config_and_clock_out #(
  parameter int SERIAL_PORTS = 6,
  parameter int TICK_CYCLES = pin_cfg_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,                                  // system clock
  input wire logic rst,                                      // async reset, active high
  input wire pin_cfg_pkg::avs_req_t avs_req,                 // register bus request
  output var pin_cfg_pkg::avs_rsp_t avs_rsp,                 // register bus answer
  input wire logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_in,      // pin levels
  output var logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_out,     // pin drive values
  output var logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_oe_n,    // pin drive enables, low drives
  input wire logic [pin_cfg_pkg::PIN_COUNT-1:0] gpio_out,    // gpio data to drive
  output var logic [pin_cfg_pkg::PIN_COUNT-1:0] gpio_in,     // gpio data sampled
  input wire logic sys_mgmt_irq_out,                         // irq output function
  input wire logic kbc_port_bit7,                            // keyboard port bit 7
  input wire logic mouse_data_line_out,                      // mouse data to drive
  input wire logic mouse_clock_line_out,                     // mouse clock to drive
  input wire logic terminal_ready_p4,                        // port 4 terminal ready
  input wire logic kbc_system_reset_out,                     // keyboard system reset
  input wire logic addr20_gate_out,                          // address line 20 gate
  input wire logic drive_density_sel0,                       // drive density select 0
  input wire logic wake_event_out,                           // wake request, high asserts
  output var logic front_panel_reset_in,                     // front panel reset seen
  output var logic ring_indicator_p4,                        // port 4 ring indicator
  output var logic mouse_data_line_in,                       // mouse data sampled
  output var logic mouse_clock_line_in,                      // mouse clock sampled
  input wire pin_cfg_pkg::sp6_modem_out_t sp6_modem_out,     // port 6 modem outputs
  output var pin_cfg_pkg::sp6_modem_in_t sp6_modem_in,       // port 6 modem inputs
  input wire logic cfg_serial_in,                            // port 6 input pin
  output var logic cfg_serial_out6,                          // port 6 output pin
  output var logic slow_clk_out                              // programmable clock out
);

  localparam int NP = pin_cfg_pkg::PIN_COUNT;
  localparam int DEC_SP6 = NP;
  localparam int DEC_CLK = NP + 1;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] sp6;
    logic [7:0] clk_ctrl;
    logic [NP-1:0][7:0] pin_cfg;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe_n;
    logic [NP-1:0] gpio_in;
    logic fp_reset;
    logic ring4;
    logic mouse_data;
    logic mouse_clock;
    logic [3:0] sp6_in;
    logic serial_out6;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [NP-1:0] alt_src;
  logic [NP-1:0] alt_on;
  logic [NP-1:0] in_val;
  logic [NP+1:0] hit;
  logic [7:0] rbyte;
  logic [7:0] wbyte;
  logic req;
  logic commit;
  logic p4_ok;
  logic p6_ok;
  logic [7:0] cfg;
  logic val;
  logic drive;
  logic open_drain;
  logic dir_level;
  logic rts_eff;
  logic dtr_eff;

  // one-hot decode of a register index; unaligned addresses hit nothing
  function automatic logic [NP+1:0] decode(input logic [pin_cfg_pkg::AVS_ADDR_W-1:0] a);
    logic [NP+1:0] h;
    logic [7:0] i;
    h = '0;
    i = a[9:2];
    if (a[1:0] == 2'h0) begin
      for (int p = 0; p < NP; p++) begin
        h[p] = (i == pin_cfg_pkg::PIN_CFG_IDX[p]);
      end
      h[DEC_SP6] = (i == pin_cfg_pkg::IDX_SERIAL_PORT6_OPTIONS);
      h[DEC_CLK] = (i == pin_cfg_pkg::IDX_SLOW_CLOCK_OUTPUT_CTRL);
    end
    return h;
  endfunction

  // writable bits of a pin register; port 4 functions exist only on larger variants
  function automatic logic [7:0] pin_wmask(input int p, input logic four_ports);
    logic [7:0] m;
    m = pin_cfg_pkg::PIN_CFG_WMASK[p];
    if ((p == pin_cfg_pkg::PIN_RING_IND4 || p == pin_cfg_pkg::PIN_TERM_READY4) && four_ports) begin
      m = m | pin_cfg_pkg::CFG_ALT_MASK;
    end
    return m;
  endfunction

  // two-bit alternate function code of a pin register
  function automatic logic [1:0] alt2_code(input logic [7:0] c);
    return c[pin_cfg_pkg::CFG_ALT2_LSB +: 2];
  endfunction

  assign p4_ok = (SERIAL_PORTS >= pin_cfg_pkg::SERIAL_PORTS_FOR_P4);
  assign p6_ok = (SERIAL_PORTS >= pin_cfg_pkg::SERIAL_PORTS_FOR_P6);

  // alternate function output sources, before polarity
  always_comb begin
    alt_src = '1;
    if (alt2_code(st_q.pin_cfg[pin_cfg_pkg::PIN_SMI_OR_KBC_BIT]) == pin_cfg_pkg::ALT2_KBC) begin
      alt_src[pin_cfg_pkg::PIN_SMI_OR_KBC_BIT] = kbc_port_bit7;
    end else begin
      alt_src[pin_cfg_pkg::PIN_SMI_OR_KBC_BIT] = sys_mgmt_irq_out;
    end
    alt_src[pin_cfg_pkg::PIN_MOUSE_DATA] = mouse_data_line_out;
    alt_src[pin_cfg_pkg::PIN_MOUSE_CLOCK] = mouse_clock_line_out;
    alt_src[pin_cfg_pkg::PIN_TERM_READY4] = terminal_ready_p4;
    alt_src[pin_cfg_pkg::PIN_KBD_RESET] = kbc_system_reset_out;
    alt_src[pin_cfg_pkg::PIN_ADDR_GATE] = addr20_gate_out;
    alt_src[pin_cfg_pkg::PIN_DENSITY0] = drive_density_sel0;
    // wake request drives the pin low when not inverted
    alt_src[pin_cfg_pkg::PIN_WAKE_EVENT] = ~wake_event_out;
  end

  always_comb begin
    st_d = st_q;
    req = avs_req.read || avs_req.write;
    hit = decode(avs_req.address);
    commit = avs_req.write && !st_q.waitreq && avs_req.byteenable[0];
    wbyte = avs_req.writedata[7:0];
    cfg = '0;
    val = 1'b0;
    drive = 1'b0;
    open_drain = 1'b0;

    // bus answer: waitrequest drops for one cycle after a request is seen
    st_d.waitreq = !(req && st_q.waitreq);
    rbyte = '0;
    for (int p = 0; p < NP; p++) begin
      if (hit[p]) begin
        rbyte = st_q.pin_cfg[p] | pin_cfg_pkg::PIN_CFG_FIXED1[p];
      end
    end
    if (hit[DEC_SP6] && p6_ok) begin
      rbyte = st_q.sp6;
    end
    if (hit[DEC_CLK]) begin
      rbyte = st_q.clk_ctrl;
    end
    st_d.rdata = '0;
    if (avs_req.read && st_q.waitreq) begin
      st_d.rdata = {24'h0, rbyte};
    end

    // register writes take effect at the edge where waitrequest is low
    if (commit) begin
      for (int p = 0; p < NP; p++) begin
        if (hit[p]) begin
          st_d.pin_cfg[p] = wbyte & pin_wmask(p, p4_ok);
        end
      end
      if (hit[DEC_SP6] && p6_ok) begin
        st_d.sp6 = wbyte & pin_cfg_pkg::SP6_WMASK;
      end
      if (hit[DEC_CLK]) begin
        st_d.clk_ctrl = wbyte & pin_cfg_pkg::CLKO_WMASK;
      end
    end

    // pin drive and sampling
    for (int p = 0; p < NP; p++) begin
      cfg = st_q.pin_cfg[p];
      if (p == pin_cfg_pkg::PIN_SMI_OR_KBC_BIT) begin
        // code 11 is reserved and behaves as plain gpio
        alt_on[p] = (alt2_code(cfg) == pin_cfg_pkg::ALT2_SMI) ||
                    (alt2_code(cfg) == pin_cfg_pkg::ALT2_KBC);
      end else begin
        alt_on[p] = cfg[pin_cfg_pkg::CFG_ALT_BIT];
      end
      val = (alt_on[p] ? alt_src[p] : gpio_out[p]) ^
            cfg[pin_cfg_pkg::CFG_POL_BIT];
      drive = !cfg[pin_cfg_pkg::CFG_DIR_BIT];
      open_drain = cfg[pin_cfg_pkg::CFG_OTYPE_BIT] ||
                   pin_cfg_pkg::PIN_CFG_FIXED1[p][pin_cfg_pkg::CFG_OTYPE_BIT];
      if (open_drain) begin
        st_d.pin_out[p] = 1'b0;
        st_d.pin_oe_n[p] = !(drive && !val);
      end else begin
        st_d.pin_out[p] = val;
        st_d.pin_oe_n[p] = !drive;
      end
      in_val[p] = pin_in[p] ^ cfg[pin_cfg_pkg::CFG_POL_BIT];
      st_d.gpio_in[p] = in_val[p];
    end

    // alternate inputs idle high while their function is not selected
    st_d.fp_reset = alt_on[pin_cfg_pkg::PIN_FRONT_PANEL_RESET] ?
                    in_val[pin_cfg_pkg::PIN_FRONT_PANEL_RESET] : 1'b1;
    st_d.ring4 = alt_on[pin_cfg_pkg::PIN_RING_IND4] ?
                 in_val[pin_cfg_pkg::PIN_RING_IND4] : 1'b1;
    st_d.mouse_data = alt_on[pin_cfg_pkg::PIN_MOUSE_DATA] ?
                      in_val[pin_cfg_pkg::PIN_MOUSE_DATA] : 1'b1;
    st_d.mouse_clock = alt_on[pin_cfg_pkg::PIN_MOUSE_CLOCK] ?
                       in_val[pin_cfg_pkg::PIN_MOUSE_CLOCK] : 1'b1;

    // port 6 automatic direction control replaces the chosen modem output
    dir_level = st_q.sp6[pin_cfg_pkg::SP6_DIR_POL_BIT] ?
                sp6_modem_out.tx_active : ~sp6_modem_out.tx_active;
    rts_eff = sp6_modem_out.request_to_send_p6;
    dtr_eff = sp6_modem_out.terminal_ready_p6;
    if (st_q.sp6[pin_cfg_pkg::SP6_DIR_EN_BIT]) begin
      if (st_q.sp6[pin_cfg_pkg::SP6_DIR_SIG_BIT]) begin
        rts_eff = dir_level;
      end else begin
        dtr_eff = dir_level;
      end
    end
    st_d.serial_out6 = st_q.sp6[pin_cfg_pkg::SP6_OUT_SEL_BIT] ? rts_eff : dtr_eff;

    // sp6_in order: carrier detect, ring, clear to send, set ready
    st_d.sp6_in = 4'hf;
    unique case (st_q.sp6[pin_cfg_pkg::SP6_IN_LSB +: 2])
      pin_cfg_pkg::SP6_IN_DCD: st_d.sp6_in[3] = cfg_serial_in;
      pin_cfg_pkg::SP6_IN_RI: st_d.sp6_in[2] = cfg_serial_in;
      pin_cfg_pkg::SP6_IN_CTS: st_d.sp6_in[1] = cfg_serial_in;
      pin_cfg_pkg::SP6_IN_DSR: st_d.sp6_in[0] = cfg_serial_in;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.waitreq <= 1'b1;
      st_q.sp6 <= pin_cfg_pkg::SP6_RESET;
      st_q.clk_ctrl <= pin_cfg_pkg::CLKO_RESET;
      st_q.pin_cfg <= pin_cfg_pkg::PIN_CFG_RESET;
      st_q.pin_oe_n <= '1;
      st_q.fp_reset <= 1'b1;
      st_q.ring4 <= 1'b1;
      st_q.mouse_data <= 1'b1;
      st_q.mouse_clock <= 1'b1;
      st_q.sp6_in <= 4'hf;
      st_q.serial_out6 <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  slow_clock_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_slow_clock_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(st_q.clk_ctrl[pin_cfg_pkg::CLKO_EN_BIT]),
    .freq_sel(st_q.clk_ctrl[pin_cfg_pkg::CLKO_FREQ_LSB +: 3]),
    .clk_out(slow_clk_out)
  );

  assign avs_rsp.readdata = st_q.rdata;
  assign avs_rsp.waitrequest = st_q.waitreq;
  assign pin_out = st_q.pin_out;
  assign pin_oe_n = st_q.pin_oe_n;
  assign gpio_in = st_q.gpio_in;
  assign front_panel_reset_in = st_q.fp_reset;
  assign ring_indicator_p4 = st_q.ring4;
  assign mouse_data_line_in = st_q.mouse_data;
  assign mouse_clock_line_in = st_q.mouse_clock;
  assign sp6_modem_in.carrier_detect_p6 = st_q.sp6_in[3];
  assign sp6_modem_in.ring_indicator_p6 = st_q.sp6_in[2];
  assign sp6_modem_in.clear_to_send_p6 = st_q.sp6_in[1];
  assign sp6_modem_in.set_ready_p6 = st_q.sp6_in[0];
  assign cfg_serial_out6 = st_q.serial_out6;

endmodule
`default_nettype wire

// ### test/pin_cfg_checker.sv
// port assertions for the pin configuration block
// assumes it is bound into pin_config_and_clock_out
`timescale 1ns/1ps
`default_nettype none
module pin_cfg_checker #(
  parameter int TICK_CYCLES = pin_cfg_pkg::TICK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire pin_cfg_pkg::avs_req_t avs_req, // bus request
  input wire pin_cfg_pkg::avs_rsp_t avs_rsp, // bus answer
  input wire logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_in, // pin levels
  input wire logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_out, // pin drive values
  input wire logic [pin_cfg_pkg::PIN_COUNT-1:0] gpio_in, // sampled gpio
  input wire pin_cfg_pkg::sp6_modem_in_t sp6_modem_in, // port 6 modem inputs
  input wire logic cfg_serial_in, // port 6 input pin
  input wire logic slow_clk_out // programmable clock
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [pin_cfg_pkg::PIN_COUNT-1:0] pin_in_q;
  logic [pin_cfg_pkg::PIN_COUNT-1:0] pol_view;
  int low_cnt_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_in_q <= '0;
      low_cnt_q <= 0;
    end else begin
      pin_in_q <= pin_in;
      low_cnt_q <= slow_clk_out ? 0 : (low_cnt_q < TICK_CYCLES ? low_cnt_q + 1 : low_cnt_q);
    end
  end
  // polarity seen per pin: only a register write may change it
  assign pol_view = gpio_in ^ pin_in_q;
  property p_wait_once;
    (avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("no answer after one wait cycle");
  property p_wait_short;
    !avs_rsp.waitrequest |=> avs_rsp.waitrequest;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("answer held too long");
  property p_wait_cause;
    $fell(avs_rsp.waitrequest) |-> $past(avs_req.read) || $past(avs_req.write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rdata_idle;
    avs_rsp.waitrequest |-> avs_rsp.readdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_rdata_hi;
    avs_rsp.readdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");
  property p_od_fixed;
    pin_out[pin_cfg_pkg::PIN_RING_IND4] == 1'b0 && pin_out[pin_cfg_pkg::PIN_TERM_READY4] == 1'b0;
  endproperty
  a_od_fixed: assert property (p_od_fixed) else $error("open-drain pin driven high");
  property p_modem_idle;
    $past(cfg_serial_in) |-> sp6_modem_in == 4'hf;
  endproperty
  a_modem_idle: assert property (p_modem_idle) else $error("modem input active");
  property p_modem_one;
    $countones(sp6_modem_in) >= 3;
  endproperty
  a_modem_one: assert property (p_modem_one) else $error("two modem inputs routed");
  property p_clk_low;
    $rose(slow_clk_out) |-> low_cnt_q >= TICK_CYCLES;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low phase too short");
  property p_pol_stable;
    $past(avs_rsp.waitrequest, 2) |-> $stable(pol_view);
  endproperty
  a_pol_stable: assert property (p_pol_stable) else $error("inversion changed");
endmodule
bind pin_config_and_clock_out pin_cfg_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .clk_sys(clk_sys), .rst(rst), .avs_req(avs_req), .avs_rsp(avs_rsp), .pin_in(pin_in),
  .pin_out(pin_out), .gpio_in(gpio_in), .sp6_modem_in(sp6_modem_in),
  .cfg_serial_in(cfg_serial_in), .slow_clk_out(slow_clk_out));
`default_nettype wire

// ### test/pin_board.sv
// board side of the pins: pull-ups and external drivers
// assumes low-active drive enables from the device
`timescale 1ns/1ps
`default_nettype none
module pin_board #(
  parameter int N = 10
) (
  input wire logic [N-1:0] pin_out, // device drive value
  input wire logic [N-1:0] pin_oe_n, // device enable, low drives
  input wire logic [N-1:0] ext_en, // board driver active
  input wire logic [N-1:0] ext_val, // board driver value
  output var logic [N-1:0] pin_in // resolved pin level
);
  // every pin has a pull-up; any driver at zero wins
  always_comb begin
    pin_in = (pin_oe_n | pin_out) & (~ext_en | ext_val);
  end
endmodule
`default_nettype wire

// ### test/test_pin_config_and_clock_out.sv
// self-checking bench for the pin configuration block
// assumes package, design, board model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_pin_config_and_clock_out;
  localparam int TICK = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pin_cfg_pkg::avs_req_t req = '0;
  pin_cfg_pkg::avs_rsp_t rsp;
  pin_cfg_pkg::sp6_modem_out_t mo = '0;
  pin_cfg_pkg::sp6_modem_in_t mi;
  logic [9:0] pin_in, pin_out, pin_oe_n, gpio_in;
  logic [9:0] gpio_out = '0, ext_en = '0, ext_val = '0;
  logic [8:0] src = '0;
  logic [3:0] alt_in;
  logic ser_in = 1'b1, ser_out, sclk;
  int mismatches = 0, n_compared = 0;
  logic [7:0] m [8'h31:8'h3d];
  always #2 clk_sys = ~clk_sys;
  pin_config_and_clock_out #(.SERIAL_PORTS(6), .TICK_CYCLES(TICK)) i_pin_config_and_clock_out (
    .clk_sys(clk_sys), .rst(rst), .avs_req(req), .avs_rsp(rsp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_in(gpio_in),
    .sys_mgmt_irq_out(src[0]), .kbc_port_bit7(src[1]), .mouse_data_line_out(src[2]),
    .mouse_clock_line_out(src[3]), .terminal_ready_p4(src[4]), .kbc_system_reset_out(src[5]),
    .addr20_gate_out(src[6]), .drive_density_sel0(src[7]), .wake_event_out(src[8]),
    .front_panel_reset_in(alt_in[0]), .ring_indicator_p4(alt_in[1]),
    .mouse_data_line_in(alt_in[2]), .mouse_clock_line_in(alt_in[3]), .sp6_modem_out(mo),
    .sp6_modem_in(mi), .cfg_serial_in(ser_in), .cfg_serial_out6(ser_out), .slow_clk_out(sclk));
  pin_board #(.N(10)) i_pin_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [7:0] wmask(input int a);
    case (a)
      8'h31: return 8'h3f;
      8'h32: return 8'h8f;
      8'h34, 8'h37: return 8'h07;
      8'h38: return 8'h00;
      8'h3c: return 8'h0f;
      default: return 8'h87;
    endcase
  endfunction
  function automatic logic [7:0] rstval(input int a);
    case (a)
      8'h31: return 8'h04;
      8'h33: return 8'h05;
      8'h35, 8'h36: return 8'h84;
      8'h38, 8'h3c: return 8'h00;
      default: return 8'h01;
    endcase
  endfunction
  // one bus transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] ad, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    req.read <= !w;
    req.write <= w;
    req.address <= ad;
    req.writedata <= d;
    req.byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    check(n, 2, "bus answer");
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, 10'(a * 4), {24'($urandom), d}, 4'hf, q);
    m[a] = (m[a] & ~wmask(a)) | (d & wmask(a));
  endtask
  task automatic rd(input int a);
    logic [31:0] q;
    bus(1'b0, 10'(a * 4), '0, 4'hf, q);
    check(q, {24'h0, m[a] | ((a == 8'h34 || a == 8'h37) ? 8'h80 : 8'h00)}, "reg");
  endtask
  task automatic pin_case(input int p, input logic [7:0] c);
    logic v, od, w;
    int a;
    a = p < 6 ? 8'h32 + p : (p < 9 ? 8'h33 + p : 8'h3d);
    od = c[7] || p == 2 || p == 5;
    gpio_out <= 10'($urandom);
    ext_en <= (c[0] || od) ? 10'($urandom) : 10'h000;
    ext_val <= 10'($urandom);
    src <= 9'($urandom);
    wr(a, c);
    repeat (4) @(posedge clk_sys);
    case (p)
      0: v = c[3:2] == 2'h1 ? src[0] : (c[3:2] == 2'h2 ? src[1] : gpio_out[0]);
      9: v = c[2] ? !src[8] : gpio_out[9];
      1, 2: v = gpio_out[p];
      default: v = c[2] ? src[p - 1] : gpio_out[p];
    endcase
    v = v ^ c[1];
    w = (c[0] | v) & (!ext_en[p] | ext_val[p]);
    check(pin_oe_n[p], c[0] || (od && v), "drive enable");
    if (!c[0] && !od) check(pin_out[p], v, "drive value");
    check(gpio_in[p], w ^ c[1], "gpio in");
    if (p >= 1 && p <= 4) check(alt_in[p - 1], c[2] ? w ^ c[1] : 1'b1, "alt in");
  endtask
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] c;
    logic [3:0] e;
    logic dl, rts, dtr;
    int p, n;
    q = $urandom(3);
    for (int a = 8'h31; a <= 8'h3d; a++) m[a] = rstval(a);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 8'h31; a <= 8'h3d; a++) rd(a);
    for (int r = 0; r < 3; r++) begin
      for (int a = 8'h31; a <= 8'h3d; a++) begin
        c = 8'($urandom);
        if ((a == 8'h35 || a == 8'h36) && c[2]) c[0] = 1'b0;
        wr(a, c);
        bus(1'b1, 10'(a * 4), 32'($urandom), 4'he, q);
        rd(a);
      end
    end
    bus(1'b0, 10'h0c9, '0, 4'hf, q);
    check(q, 0, "unaligned read");
    for (int k = 0; k < 80; k++) begin
      p = k % 10;
      c = 8'($urandom);
      if ((p == 1 || p == 2) && c[2]) c[0] = 1'b1;
      if ((p == 3 || p == 4) && c[2]) c[0] = 1'b0;
      pin_case(p, c);
    end
    for (int k = 0; k < 32; k++) begin
      c = 8'($urandom);
      mo <= 3'($urandom);
      ser_in <= 1'($urandom);
      wr(8'h31, c);
      repeat (3) @(posedge clk_sys);
      dl = c[5] ? mo.tx_active : !mo.tx_active;
      rts = c[3] && c[4] ? dl : mo.request_to_send_p6;
      dtr = c[3] && !c[4] ? dl : mo.terminal_ready_p6;
      check(ser_out, c[0] ? rts : dtr, "serial out");
      e = 4'hf;
      e[c[2:1]] = ser_in;
      check(mi, e, "serial in");
    end
    for (int code = 0; code < 8; code++) begin
      wr(8'h3c, 8'h00);
      repeat (2) @(posedge clk_sys);
      check(sclk, 0, "clock off");
      wr(8'h3c, {4'h0, 3'(code), 1'b1});
      n = 0;
      while (sclk !== 1'b1 && n < 600) begin
        @(posedge clk_sys);
        n++;
      end
      if (code == 7) begin
        check(n, 600, "reserved rate");
      end else begin
        n = 0;
        while (sclk === 1'b1 && n < 600) begin
          @(posedge clk_sys);
          n++;
        end
        check(n, (64 >> code) * TICK, "half period");
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
